// >>> hw/pwdt_pkg.sv
// Package for the programmable watchdog timer: register map, fields, reset values, types
package pwdt_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [4:0] ADDR_CTRL       = 5'h00;
  localparam logic [4:0] ADDR_SERVICE    = 5'h04;
  localparam logic [4:0] ADDR_COUNT      = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_MASK   = 5'h10;

  // Control register fields
  localparam int CTRL_PRESCALE_BIT = 0;
  localparam int CTRL_RELOAD_LSB   = 8;
  localparam int CTRL_DISABLE_BIT  = 16;

  // Service and status register fields
  localparam int SVC_ARM_BIT     = 0;
  localparam int SVC_COMMIT_BIT  = 1;
  localparam int SVC_CAUSE_BIT   = 2;
  localparam int SVC_ENABLED_BIT = 3;

  // Interrupt status and mask fields
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam int IRQ_SERVICE_BIT  = 1;
  localparam int IRQ_REJECT_BIT   = 2;
  localparam int IRQ_WIDTH        = 3;

  // Counter geometry and prescaler
  localparam int              CNT_WIDTH     = 16;
  localparam int              BYTE_WIDTH    = 8;
  localparam int              PRESC_WIDTH   = 7;
  localparam logic [6:0]      PRESC_DIV2_LAST   = 7'h01;
  localparam logic [6:0]      PRESC_DIV128_LAST = 7'h7F;
  localparam logic [15:0]     CNT_MAX       = 16'hFFFF;

  // Reset values
  localparam logic [7:0]      RELOAD_RST    = 8'h00;
  localparam logic            PRESCALE_RST  = 1'b0;
  localparam logic [15:0]     CNT_RST       = 16'h0000;
  localparam logic [2:0]      IRQ_RST       = 3'h0;
  localparam logic [31:0]     DATA_ZERO     = 32'h0000_0000;

  // Length of the internal reset pulse raised on overflow
  localparam int WDRST_TIME_NS = 160;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WDRST_CYCLES  = (WDRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic       disabled;
    logic [7:0] reload;
    logic       prescaleSel;
  } pwdt_ctrl_t;

  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_RESET = 1'b1
  } pwdt_state_t;

endpackage

// >>> hw/pwdt_top.sv
// Programmable watchdog timer with Wishbone classic register slave
//
// Summary of operation
// - The watchdog is a 16-bit up-counter advancing once per prescaled tick.
// - The prescale select bit picks a tick of clock/2 when 0 and clock/128 when 1.
// - Each completed service loads the counter upper byte from the reload value.
// - Each completed service clears the counter lower byte to zero.
// - After any reset the watchdog is enabled and counting with no software action.
// - Once disabled, enabling again is ignored until the next reset.
// - Counter overflow before a service raises an internal system reset.
// - A watchdog-caused reset sets a readable cause flag distinct from external reset.
// - Service needs an arm write followed by a commit write in consecutive accesses.
// - In idle or power-down the counter freezes and no watchdog reset is raised.
// - Service to overflow lasts 2^(1+6*sel) * (2^16 - reload*2^8) clock periods.
`timescale 1ns/1ns

module pwdt_top #(
  parameter int WdResetCycles = pwdt_pkg::WDRST_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output      logic        wb_ack_o,
  input  wire logic        idleMode,
  input  wire logic        powerDownMode,
  output      logic        wdtResetOut,
  output      logic        irqOut
);

  localparam logic [7:0] RstLen = 8'(WdResetCycles);

  // Bus registers
  logic [31:0]          rdData_r;
  logic [31:0]          rdData_nxt;
  logic                 ack_r;
  logic                 ack_nxt;

  // Watchdog state
  pwdt_pkg::pwdt_ctrl_t  ctrl_r;
  pwdt_pkg::pwdt_ctrl_t  ctrl_nxt;
  pwdt_pkg::pwdt_state_t state_r;
  pwdt_pkg::pwdt_state_t state_nxt;
  logic [15:0]          count_r;
  logic [15:0]          count_nxt;
  logic [6:0]           presc_r;
  logic [6:0]           presc_nxt;
  logic                 armed_r;
  logic                 armed_nxt;
  logic                 cause_r;
  logic                 cause_nxt;
  logic [7:0]           rstCnt_r;
  logic [7:0]           rstCnt_nxt;
  logic                 wdRst_r;
  logic                 wdRst_nxt;

  // Interrupt registers
  logic [2:0]           irqStat_r;
  logic [2:0]           irqStat_nxt;
  logic [2:0]           irqMask_r;
  logic [2:0]           irqMask_nxt;
  logic                 irq_r;
  logic                 irq_nxt;

  // Decoded bus access
  logic                 access;
  logic                 wrAccess;
  logic                 hitCtrl;
  logic                 hitSvc;
  logic                 hitCount;
  logic                 hitStat;
  logic                 hitMask;
  logic                 svcWrite;
  logic                 armWrite;
  logic                 commitWrite;
  logic                 serviceOk;
  logic                 serviceRej;
  logic                 running;
  logic                 tick;
  logic                 overflow;
  logic [6:0]           prescLast;
  logic [2:0]           irqEvents;

  // Request taken once; ack follows on the next edge
  assign access   = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wrAccess = access & wb_we_i;
  // Only full word offsets decode; anything else reads zero
  assign hitCtrl  = (wb_adr_i == pwdt_pkg::ADDR_CTRL);
  assign hitSvc   = (wb_adr_i == pwdt_pkg::ADDR_SERVICE);
  assign hitCount = (wb_adr_i == pwdt_pkg::ADDR_COUNT);
  assign hitStat  = (wb_adr_i == pwdt_pkg::ADDR_IRQ_STATUS);
  assign hitMask  = (wb_adr_i == pwdt_pkg::ADDR_IRQ_MASK);

  // Both bits set is a commit, never a fresh arm
  assign svcWrite    = wrAccess & hitSvc & wb_sel_i[0];
  assign armWrite    = svcWrite & wb_dat_i[pwdt_pkg::SVC_ARM_BIT] &
                       ~wb_dat_i[pwdt_pkg::SVC_COMMIT_BIT];
  assign commitWrite = svcWrite & wb_dat_i[pwdt_pkg::SVC_COMMIT_BIT];
  // A commit during the own reset pulse is no service
  assign serviceOk   = commitWrite & armed_r & (state_r == pwdt_pkg::ST_RUN);
  assign serviceRej  = commitWrite & ~armed_r;

  // Counting stops when disabled, in a power saving mode or during own reset
  assign running = ~ctrl_r.disabled & ~idleMode & ~powerDownMode &
                   (state_r == pwdt_pkg::ST_RUN);
  // Tick on the last prescaler count, then wrap to zero
  assign prescLast = ctrl_r.prescaleSel ? pwdt_pkg::PRESC_DIV128_LAST :
                                          pwdt_pkg::PRESC_DIV2_LAST;
  assign tick      = running & (presc_r == prescLast);
  // A service in the same cycle beats the overflow
  assign overflow  = tick & (count_r == pwdt_pkg::CNT_MAX) & ~serviceOk;

  // Control register and arm sequencing
  always_comb begin
    ctrl_nxt  = ctrl_r;
    armed_nxt = armed_r;
    if (wrAccess && hitCtrl) begin
      if (wb_sel_i[0]) begin
        ctrl_nxt.prescaleSel = wb_dat_i[pwdt_pkg::CTRL_PRESCALE_BIT];
      end
      if (wb_sel_i[1]) begin
        ctrl_nxt.reload = wb_dat_i[pwdt_pkg::CTRL_RELOAD_LSB +: pwdt_pkg::BYTE_WIDTH];
      end
      // Only setting is honoured; clearing the bit cannot re-enable
      if (wb_sel_i[2] && wb_dat_i[pwdt_pkg::CTRL_DISABLE_BIT]) begin
        ctrl_nxt.disabled = 1'b1;
      end
    end
    // Any access closes the arm window, reads included
    if (access) begin
      armed_nxt = armWrite;
    end
    if (state_r == pwdt_pkg::ST_RESET) begin
      armed_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_r.disabled    <= 1'b0;
      ctrl_r.reload      <= pwdt_pkg::RELOAD_RST;
      ctrl_r.prescaleSel <= pwdt_pkg::PRESCALE_RST;
      armed_r            <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      armed_r <= armed_nxt;
    end
  end

  // Counter, prescaler and internal reset sequencing
  always_comb begin
    count_nxt  = count_r;
    presc_nxt  = presc_r;
    state_nxt  = state_r;
    rstCnt_nxt = rstCnt_r;
    wdRst_nxt  = 1'b0;
    cause_nxt  = cause_r;
    case (state_r)
      pwdt_pkg::ST_RUN: begin
        // Prescaler restarts so the period counts from the service edge
        if (serviceOk) begin
          count_nxt = {ctrl_r.reload, 8'h00};
          presc_nxt = '0;
        end else if (running) begin
          presc_nxt = tick ? 7'h00 : 7'(presc_r + 7'h01);
          if (tick) begin
            count_nxt = 16'(count_r + 16'h0001);
          end
        end
        // Pulse leaves a flop one cycle after the overflow tick
        if (overflow) begin
          state_nxt  = pwdt_pkg::ST_RESET;
          rstCnt_nxt = RstLen;
          wdRst_nxt  = 1'b1;
          cause_nxt  = 1'b1;
        end
      end
      pwdt_pkg::ST_RESET: begin
        // Own reinitialisation resets counter and prescaler; control and interrupt registers keep their values, the cause flag stays set
        count_nxt = pwdt_pkg::CNT_RST;
        presc_nxt = '0;
        wdRst_nxt = 1'b1;
        // Count the pulse down; its last cycle hands back to run
        if (rstCnt_r <= 8'h01) begin
          state_nxt  = pwdt_pkg::ST_RUN;
          rstCnt_nxt = 8'h00;
          wdRst_nxt  = 1'b0;
        end else begin
          rstCnt_nxt = 8'(rstCnt_r - 8'h01);
        end
      end
      default: begin
        state_nxt = pwdt_pkg::ST_RUN;
      end
    endcase
    // Software clear loses against a new watchdog reset
    if (svcWrite && wb_dat_i[pwdt_pkg::SVC_CAUSE_BIT] && !overflow) begin
      cause_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_r  <= pwdt_pkg::CNT_RST;
      presc_r  <= '0;
      state_r  <= pwdt_pkg::ST_RUN;
      rstCnt_r <= 8'h00;
      wdRst_r  <= 1'b0;
      cause_r  <= 1'b0;
    end else begin
      count_r  <= count_nxt;
      presc_r  <= presc_nxt;
      state_r  <= state_nxt;
      rstCnt_r <= rstCnt_nxt;
      wdRst_r  <= wdRst_nxt;
      cause_r  <= cause_nxt;
    end
  end

  // Interrupt status, mask and output
  // Event order matches the status bit layout
  assign irqEvents = {serviceRej, serviceOk, overflow};

  always_comb begin
    irqStat_nxt = irqStat_r;
    irqMask_nxt = irqMask_r;
    if (wrAccess && hitStat && wb_sel_i[0]) begin
      irqStat_nxt = irqStat_r & ~wb_dat_i[pwdt_pkg::IRQ_WIDTH-1:0];
    end
    // A new mask acts on the interrupt at the same edge
    if (wrAccess && hitMask && wb_sel_i[0]) begin
      irqMask_nxt = wb_dat_i[pwdt_pkg::IRQ_WIDTH-1:0];
    end
    // Set after clear so a same-cycle event survives
    irqStat_nxt = irqStat_nxt | irqEvents;
    irq_nxt     = |(irqStat_nxt & irqMask_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irqStat_r <= pwdt_pkg::IRQ_RST;
      irqMask_r <= pwdt_pkg::IRQ_RST;
      irq_r     <= 1'b0;
    end else begin
      irqStat_r <= irqStat_nxt;
      irqMask_r <= irqMask_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // Bus slave: one wait state, unmapped reads return zero
  always_comb begin
    ack_nxt    = access;
    rdData_nxt = rdData_r;
    if (access) begin
      // Writes answer with zero data
      rdData_nxt = pwdt_pkg::DATA_ZERO;
      if (!wb_we_i) begin
        if (hitCtrl) begin
          rdData_nxt[pwdt_pkg::CTRL_PRESCALE_BIT] = ctrl_r.prescaleSel;
          rdData_nxt[pwdt_pkg::CTRL_RELOAD_LSB +: pwdt_pkg::BYTE_WIDTH] = ctrl_r.reload;
          rdData_nxt[pwdt_pkg::CTRL_DISABLE_BIT] = ctrl_r.disabled;
        end
        if (hitSvc) begin
          rdData_nxt[pwdt_pkg::SVC_ARM_BIT]     = armed_r;
          rdData_nxt[pwdt_pkg::SVC_CAUSE_BIT]   = cause_r;
          rdData_nxt[pwdt_pkg::SVC_ENABLED_BIT] = ~ctrl_r.disabled;
        end
        if (hitCount) begin
          rdData_nxt[pwdt_pkg::CNT_WIDTH-1:0] = count_r;
        end
        if (hitStat) begin
          rdData_nxt[pwdt_pkg::IRQ_WIDTH-1:0] = irqStat_r;
        end
        if (hitMask) begin
          rdData_nxt[pwdt_pkg::IRQ_WIDTH-1:0] = irqMask_r;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ack_r    <= 1'b0;
      rdData_r <= pwdt_pkg::DATA_ZERO;
    end else begin
      ack_r    <= ack_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  // Every output comes straight from a flop
  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = rdData_r;
  assign wdtResetOut = wdRst_r;
  assign irqOut      = irq_r;

endmodule // pwdt_top

// >>> verif/pwdt_checker.sv
// Port-level assertions for the watchdog timer
`timescale 1ns/1ns
module pwdt_checker #(
  parameter int WdResetCycles = pwdt_pkg::WDRST_CYCLES
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_ack_o,
  input wire logic        idleMode,
  input wire logic        powerDownMode,
  input wire logic        wdtResetOut,
  input wire logic        irqOut
);
  logic [7:0] rstLen_r;
  logic [7:0] rstLen_nxt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  always_comb rstLen_nxt = wdtResetOut ? rstLen_r + 8'h01 : 8'h00;
  always_ff @(posedge ref_clk) rstLen_r <= reset_n ? rstLen_nxt : 8'h00;
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
  a_ack_pulse: assert property (s_take |=> s_pulse)
    else $error("ack is not a single pulse");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_hold: assert property (!wb_ack_o && $past(reset_n) |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_write_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
    else $error("write ack carries data");
  a_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 5'h10)
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_rst_len: assert property ($fell(wdtResetOut) && $past(reset_n)
    |-> rstLen_r == 8'(WdResetCycles)) else $error("reset pulse length wrong");
  a_idle_norst: assert property ((idleMode || powerDownMode)[*3] |-> !$rose(wdtResetOut))
    else $error("reset raised while frozen");
  a_rst_gap: assert property ($fell(wdtResetOut) |-> !wdtResetOut[*8])
    else $error("reset pulse retriggered");
endmodule // pwdt_checker

bind pwdt_top pwdt_checker #(.WdResetCycles(WdResetCycles)) uChk (
  .ref_clk(ref_clk), .reset_n(reset_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i),
  .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .idleMode(idleMode),
  .powerDownMode(powerDownMode), .wdtResetOut(wdtResetOut), .irqOut(irqOut));

// >>> verif/test_programmable_watchdog_timer.sv
// Self-checking bench for the watchdog timer
`timescale 1ns/1ns
module test_programmable_watchdog_timer;
  logic        ref_clk, reset_n, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
  logic        idleMode, powerDownMode, wdtResetOut, irqOut;
  logic [4:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, c0;
  logic [7:0]  r;
  int          numErrors = 0, totalChecks = 0, cycleCnt = 0, t0;

  pwdt_top #(.WdResetCycles(2)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
    .idleMode(idleMode), .powerDownMode(powerDownMode), .wdtResetOut(wdtResetOut),
    .irqOut(irqOut));

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cycleCnt <= cycleCnt + 1;
  // Longest tests need about 33k cycles
  initial begin
    #900_000;
    numErrors++;
    end_sim;
  end

  function automatic logic [31:0] wdt_period(input logic sel, input logic [7:0] rl);
    return (32'h1 << (sel ? 7 : 1)) * (32'h10000 - {16'h0, rl, 8'h00});
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    {wb_adr_i, wb_we_i, wb_dat_i, wb_sel_i, wb_cyc_i, wb_stb_i} <= {a, w, d, s, 2'h3};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) numErrors++;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [4:0] a);
    wb(a, 1'h0, 32'h0, 4'hF);
  endtask
  task automatic period(input logic sel, input logic [7:0] rl);
    wb(pwdt_pkg::ADDR_CTRL, 1'h1, {16'h0, rl, 7'h0, sel}, 4'hF);
    wb(pwdt_pkg::ADDR_SERVICE, 1'h1, 32'h1, 4'hF);
    wb(pwdt_pkg::ADDR_SERVICE, 1'h1, 32'h2, 4'hF);
    t0 = cycleCnt;
    rd(pwdt_pkg::ADDR_COUNT);
    chk("count high", q[15:8], rl);
    chk("count low", q[7:0] < 8'h08, 1);
    while (wdtResetOut !== 1'h1 && cycleCnt - t0 < 40000) @(posedge ref_clk);
    t0 = cycleCnt - t0;
    chk("period", t0 + 4 >= wdt_period(sel, rl) && t0 <= wdt_period(sel, rl) + 2, 1);
    $display("test period sel %0d reload %h done", sel, rl);
  endtask

  initial begin
    {reset_n, wb_cyc_i, wb_stb_i, wb_we_i, idleMode, powerDownMode} = 6'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    void'($urandom(53));
    r = 8'hFC + 8'($urandom_range(3, 0));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    rd(pwdt_pkg::ADDR_CTRL);
    chk("ctrl reset", q, 32'h0);
    rd(pwdt_pkg::ADDR_SERVICE);
    chk("service reset", q, 32'h8);
    rd(5'h14);
    chk("unmapped", q, 32'h0);
    rd(pwdt_pkg::ADDR_COUNT);
    chk("counting", q != 32'h0, 1);
    $display("test reset done");
    // Reload lane only, so a stray commit would show FF in the high byte
    wb(pwdt_pkg::ADDR_CTRL, 1'h1, 32'hFFFF_FF00, 4'h2);
    rd(pwdt_pkg::ADDR_CTRL);
    chk("ctrl lanes", q, 32'h0000_FF00);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) begin
        wb(pwdt_pkg::ADDR_SERVICE, 1'h1, 32'h1, 4'hF);
        rd(pwdt_pkg::ADDR_CTRL);
      end
      wb(pwdt_pkg::ADDR_SERVICE, 1'h1, 32'h2, 4'hF);
      rd(pwdt_pkg::ADDR_COUNT);
      chk("no reload", q[15:8] !== 8'hFF, 1);
      rd(pwdt_pkg::ADDR_IRQ_STATUS);
      chk("rejected", q[2], 1);
      wb(pwdt_pkg::ADDR_IRQ_STATUS, 1'h1, 32'h7, 4'hF);
    end
    $display("test refused commit done");
    period(1'h0, r);
    period(1'h1, 8'hFF);
    while (wdtResetOut === 1'h1) @(posedge ref_clk);
    rd(pwdt_pkg::ADDR_SERVICE);
    chk("cause", q, 32'hC);
    chk("irq masked", irqOut, 0);
    wb(pwdt_pkg::ADDR_IRQ_MASK, 1'h1, 32'h1, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk("irq on", irqOut, 1);
    wb(pwdt_pkg::ADDR_IRQ_STATUS, 1'h1, 32'h7, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk("irq off", irqOut, 0);
    wb(pwdt_pkg::ADDR_SERVICE, 1'h1, 32'h4, 4'hF);
    rd(pwdt_pkg::ADDR_SERVICE);
    chk("cause clear", q, 32'h8);
    $display("test overflow done");
    // Shortest period, so a leaky freeze would overflow while parked
    wb(pwdt_pkg::ADDR_CTRL, 1'h1, 32'h0000_FF00, 4'hF);
    wb(pwdt_pkg::ADDR_SERVICE, 1'h1, 32'h1, 4'hF);
    wb(pwdt_pkg::ADDR_SERVICE, 1'h1, 32'h2, 4'hF);
    for (int i = 0; i < 2; i++) begin
      {idleMode, powerDownMode} <= i ? 2'h1 : 2'h2;
      rd(pwdt_pkg::ADDR_COUNT);
      c0 = q;
      repeat (600) @(posedge ref_clk);
      rd(pwdt_pkg::ADDR_COUNT);
      chk("frozen", q, c0);
      {idleMode, powerDownMode} <= 2'h0;
      @(posedge ref_clk);
    end
    rd(pwdt_pkg::ADDR_SERVICE);
    chk("no reset frozen", q[2], 0);
    rd(pwdt_pkg::ADDR_COUNT);
    chk("resumed", q[15:0] > c0[15:0], 1);
    $display("test freeze done");
    wb(pwdt_pkg::ADDR_CTRL, 1'h1, 32'h0001_0000, 4'hF);
    rd(pwdt_pkg::ADDR_SERVICE);
    chk("disabled", q[3], 0);
    wb(pwdt_pkg::ADDR_CTRL, 1'h1, 32'h0, 4'hF);
    rd(pwdt_pkg::ADDR_SERVICE);
    chk("stay disabled", q[3], 0);
    rd(pwdt_pkg::ADDR_COUNT);
    c0 = q;
    rd(pwdt_pkg::ADDR_COUNT);
    chk("stopped", q, c0);
    reset_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    rd(pwdt_pkg::ADDR_SERVICE);
    chk("re-enabled", q, 32'h8);
    $display("test disable done");
    end_sim;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
endmodule // test_programmable_watchdog_timer
